/* rtl/mcu_core.sv */
/*
 8-bit core: register file, index pointers, data space decode, fetch/execute pipeline, stack,
 interrupt vectoring, sleep modes, external sram port and a wishbone debug slave.
 assumes a combinational program memory read on the same clock and a latch-plus-sram outside.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - reset acts at once on any low level, release takes two clock cycles
// - 32 registers, read-operate-write in one cycle
// - six registers pair into three pointers
// - pointer z addresses constant table reads
// - data 0x00-0x1F maps to registers for loads only, stores there do nothing
// - 64 io locations at data 0x20-0x5F
// - next word fetched while current executes
// - one- and two-word instructions decoded
// - relative jumps reach whole program space; the 12-bit offset does so only when PROG_AW is 12 or less
// - calls and interrupts push return address
// - stack pointer read/write through io
// - one vector per source, table at zero
// - lowest vector wins among pending sources
// - global enable bit gates interrupt entry
// - latch strobe with low address, then data
// - first port becomes muxed address/data
// - third port drives high address
// - idle halts execution, interrupts still wake
// - power-down keeps state, wakes on interrupt
// - external access only with enable bit
// - sram 0x60-0x25F internal, above external
// - strobes stay idle for internal accesses
// - external byte costs one extra cycle
module mcu_core
  import mcu_core_pkg::*;
#(
  parameter int PROG_AW = 12,
  parameter int IRQ_N = 12
)(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // program memory
  output logic [PROG_AW-1:0] o_prog_addr,
  input wire logic [15:0] i_prog_word,
  // interrupt sources
  input wire logic [IRQ_N-1:0] i_irq,
  output logic [IRQ_N-1:0] o_irq_ack,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // ports and external memory
  input wire logic [7:0] i_first_port_lines,
  output logic [7:0] o_first_port_lines,
  output logic [7:0] o_first_port_oe_n,
  output logic [7:0] o_third_port_lines,
  output ext_bus_t o_ext_ctl,
  // sleep state
  output logic o_idle,
  output logic o_power_down
);
  if (PROG_AW < 8 || PROG_AW > 15 || IRQ_N < 1 || IRQ_N >= 2**PROG_AW) begin : g_chk
    $error("mcu_core: unsupported parameters");
  end

  // alu for register-register operations
  function automatic logic [7:0] alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
    case (op)
      ALU_ADD: alu = a + b;
      ALU_SUB: alu = a - b;
      ALU_AND: alu = a & b;
      ALU_EOR: alu = a ^ b;
      ALU_OR: alu = a | b;
      default: alu = b;
    endcase
  endfunction

  // data space region of an address
  function automatic region_t region(input logic [15:0] a);
    if (a < IO_BASE) region = RG_REG;
    else if (a < IRAM_BASE) region = RG_IO;
    else if (a <= IRAM_END) region = RG_IRAM;
    else region = RG_EXT;
  endfunction

  // internal sram word index
  function automatic logic [8:0] sidx(input logic [15:0] a);
    logic [15:0] d;
    d = a - IRAM_BASE;
    sidx = d[8:0];
  endfunction

  // reset release through two flops
  logic rst_meta_r, rst_n_r;
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // port a pin synchroniser
  logic [7:0] pa_meta_r, pa_sync_r;
  always_ff @(posedge i_clk_sys)
  begin
    pa_meta_r <= i_first_port_lines;
    pa_sync_r <= pa_meta_r;
  end

  // storage
  logic [7:0] rf [32]; // working registers
  logic [7:0] ram [IRAM_WORDS]; // internal sram
  logic [PROG_AW-1:0] instruction_pointer_r; // next fetch address
  logic [15:0] ir_r; // instruction being executed
  logic valid_r; // ir_r holds a real instruction
  state_t st_r;
  logic [15:0] stack_pointer_word_r;
  logic [7:0] sreg_r, mcu_control_register_r;
  logic [7:0] port_a_r, ddr_a_r, port_c_r;
  logic [15:0] ext_addr_r; // latched external address
  logic [7:0] ext_wd_r; // external write byte
  logic [4:0] ext_dst_r; // destination of external read
  logic ext_st_r; // external access is a store
  logic [7:0] ret_hi_r; // high return byte in flight
  logic ctrl_run_r; // debug run enable
  logic wb_ack_r;
  logic [31:0] wb_dat_r;

  // decode fields
  wire [15:0] w = ir_r;
  wire [4:0] rd = w[8:4];
  wire [4:0] rr = {w[9], w[3:0]};
  wire is_ldi = w[15:12] == OPG_LDI;
  wire is_alu = w[15:14] == 2'b00 && (w[13:10] == ALU_ADD || w[13:10] == ALU_SUB ||
    w[13:10] == ALU_AND || w[13:10] == ALU_EOR || w[13:10] == ALU_OR || w[13:10] == ALU_MOV);
  wire is_ldd = w[15:14] == OPG_DISP && !w[12];
  wire is_ldx = w[15:10] == OPG_LDST && (w[3:0] == 4'hC || w[3:0] == 4'hD || w[3:0] == 4'h9 ||
    w[3:0] == 4'h1 || w[3:0] == 4'h0);
  wire is_lds = is_ldx && w[3:0] == 4'h0;
  wire is_io = w[15:12] == OPG_IO;
  wire is_mem = is_ldd || is_ldx || is_io;
  wire m_store = is_io ? w[11] : w[9];
  wire is_rjmp = w[15:12] == OPG_RJMP;
  wire is_rcall = w[15:12] == OPG_RCALL;
  wire [4:0] ptr_sel = is_ldd ? (w[3] ? PTR_Y : PTR_Z) : (w[3:2] == 2'b11 ? PTR_X : (w[3:2] == 2'b10 ? PTR_Y : PTR_Z));
  wire [15:0] ptr_val = {rf[ptr_sel + 5'd1], rf[ptr_sel]};
  wire [15:0] ptr_inc = ptr_val + 16'h0001;
  wire post_inc = is_ldx && !is_lds && w[0];
  wire [15:0] disp = is_ldd ? {10'h000, w[13], w[11:10], w[2:0]} : 16'h0000;
  wire [15:0] m_addr = is_io ? IO_BASE + {10'h000, w[10:9], w[3:0]} : (is_lds ? i_prog_word : ptr_val + disp);
  wire [15:0] io_off = m_addr - IO_BASE;
  wire [5:0] io_a = io_off[5:0];
  wire region_t rg = region(m_addr);
  wire ext_en = mcu_control_register_r[EXTERNAL_MEMORY_ENABLE_BIT];
  wire [15:0] z_val = {rf[PTR_Z + 5'd1], rf[PTR_Z]};

  wire irq_take = st_r == S_RUN && ctrl_run_r && valid_r && sreg_r[SREG_I] && |i_irq;
  wire do_ex = st_r == S_RUN && ctrl_run_r && valid_r && !irq_take;
  wire ext_go = do_ex && is_mem && rg == RG_EXT && ext_en;
  wire [IRQ_N-1:0] irq_one = i_irq & (~i_irq + {{(IRQ_N-1){1'b0}}, 1'b1});
  logic [PROG_AW-1:0] vec;
  always_comb
  begin
    vec = '0;
    for (int i = IRQ_N - 1; i >= 0; i--)
      if (i_irq[i]) vec = PROG_AW'(i + VEC_FIRST);
  end
  wire [PROG_AW-1:0] ret_addr = irq_take ? instruction_pointer_r - 1'b1 : instruction_pointer_r;
  wire [15:0] push_word = 16'(ret_addr);
  wire [15:0] sp_up = stack_pointer_word_r + 16'h0001;
  wire [15:0] rel = 16'(instruction_pointer_r) + {{4{w[11]}}, w[11:0]};

  // io reads
  logic [7:0] io_rd;
  always_comb
  begin
    case (io_a)
      IO_STACK_LO: io_rd = stack_pointer_word_r[7:0];
      IO_STACK_HI: io_rd = stack_pointer_word_r[15:8];
      IO_STATUS: io_rd = sreg_r;
      IO_MCU_CTRL: io_rd = mcu_control_register_r;
      IO_PORT_A_OUT: io_rd = port_a_r;
      IO_PORT_A_DIR: io_rd = ddr_a_r;
      IO_PORT_A_PIN: io_rd = pa_sync_r;
      IO_PORT_C_OUT: io_rd = port_c_r;
      default: io_rd = 8'h00;
    endcase
  end

  wire [7:0] rd_val = rg == RG_REG ? rf[m_addr[4:0]] : (rg == RG_IO ? io_rd : (rg == RG_IRAM ? ram[sidx(m_addr)] : 8'h00));

  // register file write port
  wire lpm_wr = st_r == S_LPM;
  wire ext_rd_done = st_r == S_EXT && !ext_st_r;
  wire ld_int = do_ex && is_mem && !m_store && rg != RG_EXT;
  wire rf_we = (do_ex && (is_ldi || is_alu)) || ld_int || ext_rd_done || lpm_wr;
  wire [4:0] rf_wa = ext_rd_done ? ext_dst_r : (lpm_wr ? 5'h00 : (is_ldi ? {1'b1, w[7:4]} : rd));
  // byte chosen by z low bit
  wire [7:0] lpm_byte = z_val[0] ? i_prog_word[15:8] : i_prog_word[7:0];
  wire [7:0] rf_wd = ext_rd_done ? i_first_port_lines : (lpm_wr ? lpm_byte :
    (is_ldi ? {w[11:8], w[3:0]} : (is_alu ? alu(w[13:10], rf[rd], rf[rr]) : rd_val)));

  // sram write port
  wire push_lo = irq_take || (do_ex && is_rcall);
  wire ram_st = do_ex && is_mem && m_store && rg == RG_IRAM;
  wire sp_in = region(stack_pointer_word_r) == RG_IRAM;
  wire ram_we = ram_st || ((push_lo || st_r == S_PUSH) && sp_in);
  wire [8:0] ram_wa = ram_st ? sidx(m_addr) : sidx(stack_pointer_word_r);
  wire [7:0] ram_wd = ram_st ? rf[rd] : (push_lo ? push_word[7:0] : ret_hi_r);
  wire io_we = do_ex && is_mem && m_store && rg == RG_IO;

  always_ff @(posedge i_clk_sys)
  begin
    if (do_ex && post_inc)
    begin
      rf[ptr_sel] <= ptr_inc[7:0];
      rf[ptr_sel + 5'd1] <= ptr_inc[15:8];
    end
    if (rf_we)
      rf[rf_wa] <= rf_wd;
    if (ram_we)
      ram[ram_wa] <= ram_wd;
  end

  // sequencing, fetch and control registers, reset by the synchronised copy
  always_ff @(posedge i_clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      instruction_pointer_r <= '0;
      ir_r <= 16'h0000;
      valid_r <= 1'b0;
      st_r <= S_RUN;
      stack_pointer_word_r <= 16'h0000;
      sreg_r <= 8'h00;
      mcu_control_register_r <= 8'h00;
      port_a_r <= 8'h00;
      ddr_a_r <= 8'h00;
      port_c_r <= 8'h00;
      ext_addr_r <= 16'h0000;
      ext_wd_r <= 8'h00;
      ext_dst_r <= 5'h00;
      ext_st_r <= 1'b0;
      ret_hi_r <= 8'h00;
    end
    else
    begin
      case (st_r)
        S_RUN:
        if (ctrl_run_r)
        begin
          ir_r <= i_prog_word;
          instruction_pointer_r <= instruction_pointer_r + 1'b1;
          valid_r <= 1'b1;
          if (irq_take)
          begin
            sreg_r[SREG_I] <= 1'b0;
            instruction_pointer_r <= vec;
            valid_r <= 1'b0;
            ret_hi_r <= push_word[15:8];
            stack_pointer_word_r <= stack_pointer_word_r - 16'h0001;
            st_r <= S_PUSH;
          end
          else if (valid_r)
          begin
            if (is_lds)
              valid_r <= 1'b0;
            // latch address for the strobe cycle
            if (ext_go)
            begin
              ext_addr_r <= m_addr;
              ext_wd_r <= rf[rd];
              ext_dst_r <= rd;
              ext_st_r <= m_store;
              st_r <= S_EXT;
            end
            if (io_we)
            begin
              case (io_a)
                IO_STACK_LO: stack_pointer_word_r[7:0] <= rf[rd];
                IO_STACK_HI: stack_pointer_word_r[15:8] <= rf[rd];
                IO_STATUS: sreg_r <= rf[rd];
                IO_MCU_CTRL: mcu_control_register_r <= rf[rd];
                IO_PORT_A_OUT: port_a_r <= rf[rd];
                IO_PORT_A_DIR: ddr_a_r <= rf[rd];
                IO_PORT_C_OUT: port_c_r <= rf[rd];
                default: ;
              endcase
            end
            if (is_rjmp || is_rcall)
            begin
              instruction_pointer_r <= rel[PROG_AW-1:0];
              valid_r <= 1'b0;
            end
            if (is_rcall)
            begin
              ret_hi_r <= push_word[15:8];
              stack_pointer_word_r <= stack_pointer_word_r - 16'h0001;
              st_r <= S_PUSH;
            end
            if (w == OP_RET || w == OP_RETI)
            begin
              ret_hi_r <= ram[sidx(sp_up)];
              stack_pointer_word_r <= sp_up;
              st_r <= S_POP;
            end
            if (w == OP_RETI || w == OP_SEI)
              sreg_r[SREG_I] <= 1'b1;
            if (w == OP_CLI)
              sreg_r[SREG_I] <= 1'b0;
            if (w == OP_SLEEP && mcu_control_register_r[MCU_SLEEP_EN])
              st_r <= S_SLEEP;
            if (w == OP_LPM)
              st_r <= S_LPM;
          end
        end
        S_EXT: st_r <= S_RUN;
        S_PUSH:
        begin
          stack_pointer_word_r <= stack_pointer_word_r - 16'h0001;
          st_r <= S_RUN;
        end
        S_POP:
        begin
          stack_pointer_word_r <= sp_up;
          instruction_pointer_r <= PROG_AW'({ret_hi_r, ram[sidx(sp_up)]});
          valid_r <= 1'b0;
          st_r <= S_RUN;
        end
        S_LPM: st_r <= S_RUN;
        S_SLEEP:
        if (|i_irq)
          st_r <= S_RUN;
        default: st_r <= S_RUN;
      endcase
    end
  end

  // wishbone slave, one wait state
  wire wb_req = i_wb_cyc && i_wb_stb && !wb_ack_r;
  wire [31:0] wb_rd = i_wb_adr == WB_CTRL ? {31'h0000_0000, ctrl_run_r} :
    (i_wb_adr == WB_STAT ? {5'h00, st_r, 7'h00, valid_r, 16'(instruction_pointer_r)} :
    (i_wb_adr == WB_CORE ? {sreg_r, mcu_control_register_r, stack_pointer_word_r} : 32'h0000_0000));
  always_ff @(posedge i_clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      ctrl_run_r <= RST_RUN;
    end
    else
    begin
      wb_ack_r <= wb_req;
      if (wb_req)
        wb_dat_r <= wb_rd;
      if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == WB_CTRL)
        ctrl_run_r <= i_wb_dat[0];
    end
  end
  assign o_wb_ack = wb_ack_r;
  assign o_wb_dat = wb_dat_r;

  // program port lent to table read
  assign o_prog_addr = st_r == S_LPM ? z_val[PROG_AW:1] : instruction_pointer_r;
  assign o_irq_ack = irq_take ? irq_one : '0;
  assign o_idle = st_r == S_SLEEP && !mcu_control_register_r[MCU_SLEEP_PD];
  assign o_power_down = st_r == S_SLEEP && mcu_control_register_r[MCU_SLEEP_PD];
  // read/write strobes only in the external cycle, latch strobe in the cycle before it
  assign o_ext_ctl = '{ale: ext_go, rd_n: !(st_r == S_EXT && !ext_st_r), wr_n: !(st_r == S_EXT && ext_st_r)};
  // first port carries address then data
  wire [7:0] muxed_address_data_lines = ext_go ? m_addr[7:0] : ext_wd_r;
  assign o_first_port_lines = ext_en ? muxed_address_data_lines : port_a_r;
  assign o_first_port_oe_n = ext_en ? ((ext_go || (st_r == S_EXT && ext_st_r)) ? 8'h00 : 8'hFF) : ~ddr_a_r;
  assign o_third_port_lines = ext_en ? (ext_go ? m_addr[15:8] : ext_addr_r[15:8]) : port_c_r;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n_r);
  property p_ale_strobe; o_ext_ctl.ale |=> !o_ext_ctl.ale && (!o_ext_ctl.rd_n || !o_ext_ctl.wr_n); endproperty
  a_ale_strobe: assert property (p_ale_strobe) else $error("no strobe after latch");
  property p_ext_cost; o_ext_ctl.ale |-> st_r == S_RUN ##1 st_r == S_EXT ##1 st_r == S_RUN; endproperty
  a_ext_cost: assert property (p_ext_cost) else $error("external access length wrong");
  property p_int_quiet; st_r != S_EXT |-> o_ext_ctl.rd_n && o_ext_ctl.wr_n; endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("strobe outside external cycle");
  property p_ext_gate; o_ext_ctl.ale |-> ext_en && rg == RG_EXT && o_first_port_oe_n == 8'h00; endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external access while disabled");
  property p_irq_clr; irq_take |=> !sreg_r[SREG_I] && st_r == S_PUSH ##1 st_r == S_RUN; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("entry kept global enable");
  property p_irq_prio; irq_take |-> $onehot(o_irq_ack) && (o_irq_ack & i_irq) == o_irq_ack &&
    ((o_irq_ack - 1'b1) & i_irq) == '0; endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("wrong source acknowledged");
  // the request may already be gone one cycle after the take, so look at the vector of the take cycle
  property p_vector; irq_take |=> instruction_pointer_r == $past(vec) && $past(vec) != '0; endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");
  property p_reset_ip; $rose(rst_n_r) |-> instruction_pointer_r == '0 && !valid_r; endproperty
  a_reset_ip: assert property (p_reset_ip) else $error("fetch not from zero");
  property p_sleep; st_r == S_SLEEP && !(|i_irq) |=> st_r == S_SLEEP && $stable(instruction_pointer_r); endproperty
  a_sleep: assert property (p_sleep) else $error("execution during sleep");
  property p_call_push; do_ex && is_rcall |=> st_r == S_PUSH ##1
    stack_pointer_word_r == $past(stack_pointer_word_r, 2) - 16'h0002; endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push");
endmodule

/* rtl/mcu_core_pkg.sv */
/*
 package for the 8-bit core: data space map, i/o addresses, status and control bit positions,
 opcode fields, bus register offsets, reset values and shared types.
 assumes nothing beyond a SystemVerilog compiler.
*/
package mcu_core_pkg;
  // data space map
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IRAM_BASE = 16'h0060;
  localparam logic [15:0] IRAM_END = 16'h025F;
  localparam int IRAM_WORDS = 512;
  // i/o space addresses, 64 locations
  localparam logic [5:0] IO_PORT_C_OUT = 6'h15;
  localparam logic [5:0] IO_PORT_A_PIN = 6'h19;
  localparam logic [5:0] IO_PORT_A_DIR = 6'h1A;
  localparam logic [5:0] IO_PORT_A_OUT = 6'h1B;
  localparam logic [5:0] IO_MCU_CTRL = 6'h35;
  localparam logic [5:0] IO_STACK_LO = 6'h3D;
  localparam logic [5:0] IO_STACK_HI = 6'h3E;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  // bit positions
  localparam int SREG_I = 7;
  localparam int EXTERNAL_MEMORY_ENABLE_BIT = 7;
  localparam int MCU_SLEEP_EN = 5;
  localparam int MCU_SLEEP_PD = 4;
  // index pointer base registers
  localparam logic [4:0] PTR_X = 5'h1A;
  localparam logic [4:0] PTR_Y = 5'h1C;
  localparam logic [4:0] PTR_Z = 5'h1E;
  // opcode groups and whole opcodes
  localparam logic [3:0] OPG_LDI = 4'hE;
  localparam logic [3:0] OPG_IO = 4'hB;
  localparam logic [3:0] OPG_RJMP = 4'hC;
  localparam logic [3:0] OPG_RCALL = 4'hD;
  localparam logic [5:0] OPG_LDST = 6'h24;
  localparam logic [1:0] OPG_DISP = 2'h2;
  localparam logic [3:0] ALU_ADD = 4'h3;
  localparam logic [3:0] ALU_SUB = 4'h6;
  localparam logic [3:0] ALU_AND = 4'h8;
  localparam logic [3:0] ALU_EOR = 4'h9;
  localparam logic [3:0] ALU_OR = 4'hA;
  localparam logic [3:0] ALU_MOV = 4'hB;
  localparam logic [15:0] OP_RET = 16'h9508;
  localparam logic [15:0] OP_RETI = 16'h9518;
  localparam logic [15:0] OP_SEI = 16'h9478;
  localparam logic [15:0] OP_CLI = 16'h94F8;
  localparam logic [15:0] OP_SLEEP = 16'h9588;
  localparam logic [15:0] OP_LPM = 16'h95C8;
  // first interrupt vector, reset vector is zero
  localparam int VEC_FIRST = 1;
  // wishbone register offsets
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_CORE = 8'h08;
  localparam logic RST_RUN = 1'b1;
  // shared types
  typedef enum logic [2:0] {S_RUN, S_EXT, S_PUSH, S_POP, S_LPM, S_SLEEP} state_t;
  typedef enum logic [1:0] {RG_REG, RG_IO, RG_IRAM, RG_EXT} region_t;
  typedef struct packed {logic ale; logic rd_n; logic wr_n;} ext_bus_t;
endpackage

/* bench/ext_sram_model.sv */
/*
 behavioural asynchronous sram behind an address latch, the far side of the external port.
 assumes the core's latch strobe, active-low strobes and a resolved address/data wire.
*/
`timescale 1ns/1ps
module ext_sram_model (
  // clock and strobes
  input wire logic i_clk_sys,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  // address and data
  input wire logic [7:0] i_ad,
  input wire logic [7:0] i_addr_hi,
  output logic o_drive,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:65535]; // storage array
  logic [7:0] lo_lat_r; // latched low address
  always_ff @(posedge i_clk_sys)
  begin
    if (i_ale)
      lo_lat_r <= i_ad;
    if (!i_wr_n)
      mem[{i_addr_hi, lo_lat_r}] <= i_ad;
  end
  assign o_drive = !i_rd_n;
  assign o_data = mem[{i_addr_hi, lo_lat_r}];
endmodule

/* bench/tb.sv */
/*
 testbench for the core: program memory, external sram, wishbone tasks and checks.
 assumes the core of rtl/ and the sram model of bench/.
*/
`timescale 1ns/1ps
module tb;
  import mcu_core_pkg::*;
  logic clk = 0, arst_n = 0; // clock and reset
  logic [7:0] prog_addr; // word address
  logic [15:0] rom [0:255]; // program store
  logic [11:0] irq = '0, irq_ack, first_ack; // requests
  logic cyc = 0, stb = 0, we = 0; // bus strobes
  logic [7:0] adr = '0; // bus address
  logic [31:0] wdat = '0, rdat, q; // bus data
  logic [3:0] sel = '0; // byte lanes
  logic ack; // bus answer
  logic [7:0] pa_out, pa_oe_n, pc_out, pa_tb = '0, pa_wire, sd; // port lines
  logic sdrv, idle, pd, vec_hit = 0; // misc
  ext_bus_t ctl; // strobes
  int error_cnt = 0, cmp_count = 0, ale_cnt = 0, rd_cnt = 0, wr_cnt = 0, ack_cnt = 0;
  // ext store/load, stack setup, table read, x+ and x stores, y+q loads, add, port c out, then status loop
  logic [15:0] prog [30] = '{16'hE800, 16'hBF05, 16'hE51A, 16'h9310, 16'h1234, 16'h9120, 16'h1234,
    16'h9310, 16'h0100, 16'hBF2D, 16'hE032, 16'hBF3E, 16'hE000, 16'hBF05, 16'hE2E1, 16'hE0F0, 16'h95C8,
    16'hE6A0, 16'hE0B0, 16'h920D, 16'h933C, 16'hE5CF, 16'hE0D0, 16'h8159, 16'h816A, 16'h0F56, 16'hBB55,
    16'hB349, 16'hBF4F, 16'hCFFD};
  mcu_core #(.PROG_AW(8), .IRQ_N(12)) u_mcu_core (.i_clk_sys(clk), .i_arst_n(arst_n),
    .o_prog_addr(prog_addr), .i_prog_word(rom[prog_addr]), .i_irq(irq), .o_irq_ack(irq_ack),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_first_port_lines(pa_wire), .o_first_port_lines(pa_out),
    .o_first_port_oe_n(pa_oe_n), .o_third_port_lines(pc_out), .o_ext_ctl(ctl), .o_idle(idle),
    .o_power_down(pd));
  ext_sram_model u_ext_sram_model (.i_clk_sys(clk), .i_ale(ctl.ale), .i_rd_n(ctl.rd_n),
    .i_wr_n(ctl.wr_n), .i_ad(pa_wire), .i_addr_hi(pc_out), .o_drive(sdrv), .o_data(sd));
  // resolve each address/data line from all drivers
  assign pa_wire = (~pa_oe_n & pa_out) | (pa_oe_n & (sdrv ? sd : pa_tb));
  // clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  // count strobes, interrupt takes and vector fetch
  always @(posedge clk)
  begin
    ale_cnt <= ale_cnt + (ctl.ale === 1'b1);
    rd_cnt <= rd_cnt + (ctl.rd_n === 1'b0);
    wr_cnt <= wr_cnt + (ctl.wr_n === 1'b0);
    if (|irq_ack)
      ack_cnt <= ack_cnt + 1;
    if (|irq_ack && ack_cnt == 0)
      first_ack <= irq_ack;
    if (ack_cnt != 0 && prog_addr === 8'h02)
      vec_hit <= 1'b1;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // wait for the answer however long it takes, the watchdog ends a hang
    do
      @(posedge clk);
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // verdict
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // main sequence
  initial
  begin
    for (int i = 0; i < 256; i++)
      rom[i] = (i > 0 && i < 16) ? 16'hCFFF : 16'h0000;
    rom[0] = 16'hC00F;
    // handler at vector 2: enable idle sleep, sleep, then spin
    rom[2] = 16'hE200;
    rom[3] = 16'hBF05;
    rom[4] = 16'h9588;
    for (int i = 0; i < 30; i++)
      rom[16 + i] = prog[i];
    repeat (16) @(posedge clk);
    chk(prog_addr, 0);
    chk(ctl, 3'b011);
    arst_n <= 1'b1;
    irq <= 12'h00A;
    wb(WB_CTRL, 1'b0, '0, q);
    chk(q, 32'h0000_0001);
    wb(8'h0C, 1'b0, '0, q);
    chk(q, 32'h0000_0000);
    repeat (150) @(posedge clk);
    chk(u_ext_sram_model.mem[16'h1234], 8'h5A);
    chk(ale_cnt, 2);
    chk(wr_cnt, 1);
    chk(rd_cnt, 1);
    chk(ack_cnt, 0);
    wb(WB_CORE, 1'b0, '0, q);
    chk(q, 32'h0000_025A);
    // table byte 0xE8 plus stored 0x02, read back through y+q
    chk(pc_out, 8'hEA);
    pa_tb <= 8'h80;
    while (ack_cnt == 0)
      @(posedge clk);
    // requests drop once taken so the handler can sleep
    irq <= '0;
    repeat (20) @(posedge clk);
    chk(first_ack, 12'h002);
    chk(vec_hit, 1'b1);
    chk(ack_cnt, 1);
    chk(idle, 1'b1);
    chk(pd, 1'b0);
    wb(WB_CORE, 1'b0, '0, q);
    chk(q, 32'h0020_0258);
    wb(WB_STAT, 1'b0, '0, q);
    chk(q, 32'h0501_0006);
    irq <= 12'h008;
    repeat (4) @(posedge clk);
    chk(idle, 1'b0);
    chk(ack_cnt, 1);
    end_sim();
  end
endmodule
